// >>> inc/eeprom_fe_pkg.sv
// shared constants for the serial memory front end
package eeprom_fe_pkg;

    // ======================================================
    // timing
    localparam int CLK_HZ     = 20_000_000;
    localparam int TWC_MS     = 6;  // write, status write, page erase
    localparam int TERASE_MS  = 10; // sector and chip erase
    localparam int TWC_CYC    = TWC_MS * (CLK_HZ / 1000);
    localparam int TERASE_CYC = TERASE_MS * (CLK_HZ / 1000);

    // ======================================================
    // geometry
    localparam int ARR_ADDR_W = 17;
    localparam int PAGE_W     = 8;
    localparam int ADDR_BITS  = 24;

    // ======================================================
    // pin synchroniser, order {cs_n, sck, si, hold_n, wp_n}
    localparam int         SYNC_W   = 5;
    localparam logic [4:0] SYNC_RST = 5'h13;

    // ======================================================
    // opcodes
    localparam logic [7:0] OPC_READ  = 8'h03;
    localparam logic [7:0] OPC_WRITE = 8'h02;
    localparam logic [7:0] OPC_LSET  = 8'h06;
    localparam logic [7:0] OPC_LCLR  = 8'h04;
    localparam logic [7:0] OPC_STRD  = 8'h05;
    localparam logic [7:0] OPC_STWR  = 8'h01;
    localparam logic [7:0] OPC_PGER  = 8'h42;
    localparam logic [7:0] OPC_SCER  = 8'hD8;
    localparam logic [7:0] OPC_CE    = 8'hC7;
    localparam logic [7:0] OPC_WAKE  = 8'hAB;
    localparam logic [7:0] OPC_SLEEP = 8'hB9;

    // ======================================================
    // status layout and reset values
    localparam int         SB_BUSY = 0;
    localparam int         SB_LTCH = 1;
    localparam int         SB_BP_LO = 2;
    localparam int         SB_BP_HI = 3;
    localparam int         SB_PPE  = 7;
    localparam logic [1:0] BP_RST  = 2'h0;
    localparam logic       PPE_RST = 1'b0;
    localparam logic [7:0] SIG_DEFAULT = 8'h5A; // arbitrary value

    typedef enum logic [2:0] {
        OP_WRITE, OP_STATUS, OP_PAGE_ER, OP_SECT_ER, OP_CHIP_ER
    } prog_op_t;

endpackage

// >>> src/pin_sync.sv
// two-flop synchroniser for the serial pins
`timescale 1ns/1ps
`default_nettype none

module pin_sync #(
    parameter int               WIDTH   = 1,
    parameter logic [WIDTH-1:0] RST_VAL = '0
)(
    input  wire logic             clk,     // system clock
    input  wire logic             sys_rst, // sync reset
    input  wire logic [WIDTH-1:0] d,       // raw pins
    output logic      [WIDTH-1:0] q        // synchronised
);
    logic [WIDTH-1:0] meta_q;
    logic [WIDTH-1:0] sync_q;

    // ======================================================
    // first stage feeds only the second stage
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            meta_q <= RST_VAL;
            sync_q <= RST_VAL;
        end else begin
            meta_q <= d;
            sync_q <= meta_q;
        end
    end

    assign q = sync_q;

endmodule
`default_nettype wire

// >>> src/pause_ctrl.sv
// pause (hold) state tracking
`timescale 1ns/1ps
`default_nettype none

module pause_ctrl (
    input  wire logic clk,     // system clock
    input  wire logic sys_rst, // sync reset
    input  wire logic sel,     // device selected
    input  wire logic sck_lvl, // synced serial clock
    input  wire logic hold_n,  // synced pause input
    output logic      paused   // serial activity suspended
);
    logic paused_q;
    logic paused_d;

    // ======================================================
    // pause changes only while sck is low or on deselect; a change asked
    // for with sck high waits for its falling edge
    always_comb begin
        paused_d = paused_q;
        if (!sel) begin
            paused_d = 1'b0;
        end else if (!sck_lvl) begin
            paused_d = !hold_n;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            paused_q <= 1'b0;
        end else begin
            paused_q <= paused_d;
        end
    end

    assign paused = paused_q;

    // ======================================================
    // checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    a_pause_enter: assert property (sel && !hold_n && !sck_lvl |=> paused_q)
        else $error("pause not entered with sck low");
    a_pause_defer: assert property (sel && !paused_q && sck_lvl |=> !paused_q)
        else $error("pause entered with sck high");
    a_pause_resume: assert property (paused_q && sel && hold_n && !sck_lvl |=> !paused_q)
        else $error("resume missed with sck low");
    a_resume_defer: assert property (paused_q && sel && sck_lvl |=> paused_q)
        else $error("resume with sck high");
    c_pause_seen: cover property (!paused_q ##1 paused_q [*3] ##1 !paused_q);

endmodule
`default_nettype wire

// >>> src/eeprom_front_end.sv
// serial front end of the byte memory: pins, decode, status
`timescale 1ns/1ps
`default_nettype none

// Operation
// - select while chip select low; high deselects into standby
// - a started programming cycle finishes; standby only after it
// - serial output floats while deselected
// - select rising after valid write sequence starts self-timed cycle
// - after reset one select low level is needed before any sequence
// - serial output updates after each serial clock falling edge
// - protect pin low with enable bit high blocks status writes
// - protect pin falling during a running cycle has no effect
// - input bits captured on serial clock rising edge
// - pause input low suspends without resetting sequence state
// - pause starts only with clock low, else at next falling edge
// - while paused, serial input and clock are ignored
// - resume only with clock low, else at next falling edge
// - output floats at once on pause fall, drives on rise
// - instruction collected in an eight-bit register before decode
// - all bytes move most significant bit first
// - first bit sampled on first rising edge after select falls
// - 03h reads and 02h writes the array from following address
// - 06h sets and 04h clears the write enable latch
// - 42h page, D8h sector, C7h whole-chip erase
// - ABh wakes and returns signature; B9h enters deep sleep
// - status: bit0 busy, bit1 latch, bits2-3 protect, bit7 pin enable
module eeprom_front_end
    import eeprom_fe_pkg::*;
#(
    parameter int         ADDR_W    = ARR_ADDR_W,
    parameter int         WRITE_CYC = TWC_CYC,
    parameter int         ERASE_CYC = TERASE_CYC,
    parameter logic [7:0] SIGNATURE = SIG_DEFAULT
)(
    input  wire logic              clk,         // 20 MHz clock
    input  wire logic              sys_rst,     // sync reset
    input  wire logic              cs_n,        // chip select pin
    input  wire logic              sck,         // serial clock pin
    input  wire logic              si,          // serial data in
    input  wire logic              hold_n,      // pause pin
    input  wire logic              wp_n,        // write-protect pin
    output logic                   so_o,        // serial data out
    output logic                   so_oe,       // out enable
    output logic [ADDR_W-1:0]      arr_addr,    // array address
    output logic                   arr_rd_req,  // read strobe
    input  wire logic [7:0]        arr_rd_data, // data, next cycle
    output logic                   arr_wr_stb,  // page byte strobe
    output logic [7:0]             arr_wr_data, // page byte
    output logic                   prog_start,  // cycle start pulse
    output prog_op_t               prog_op,     // cycle kind
    output logic                   standby,     // idle, deselected
    output logic                   deep_sleep,  // deep power-down
    output logic [7:0]             status       // status register
);
    localparam int TMR_MAX = (ERASE_CYC > WRITE_CYC) ? ERASE_CYC : WRITE_CYC;
    localparam int TMR_W   = $clog2(TMR_MAX + 1);

    typedef enum logic [3:0] {
        ST_STANDBY, ST_OPC, ST_ADDR, ST_WDATA, ST_SRIN,
        ST_RDATA, ST_SROUT, ST_SIGOUT, ST_SKIP
    } fsm_t;

    logic [SYNC_W-1:0] syn;
    logic s_cs_n, s_sck, s_si, s_hold_n, s_wp_n;
    logic sck_prev_q, cs_prev_q;
    logic sel, paused, sck_rise, sck_fall, cs_rise, cs_fall;
    logic rise_ok, fall_ok, out_st;
    logic [7:0] opc_in, status_w;

    fsm_t              st_q, st_d;
    logic [7:0]        sr_q, sr_d, op_q, op_d, obyte_q, obyte_d;
    logic [7:0]        wdata_q, wdata_d;
    logic [4:0]        bitn_q, bitn_d;
    logic [2:0]        obit_q, obit_d;
    logic [ADDR_W-1:0] addr_q, addr_d;
    logic [1:0]        bp_q, bp_d;
    logic [TMR_W-1:0]  tmr_q, tmr_d;
    prog_op_t          pop_q, pop_d;
    logic done_q, done_d, so_q, so_d, rd_req_q, rd_req_d;
    logic rd_pend_q, wr_stb_q, wr_stb_d, armed_q, armed_d;
    logic wel_q, wel_d, ppe_q, ppe_d, dsleep_q, dsleep_d;
    logic busy_q, busy_d, pstart_q, pstart_d;

    // ======================================================
    // pin sampling and edge detection
    pin_sync #(.WIDTH(SYNC_W), .RST_VAL(SYNC_RST)) u_sync (
        .clk     (clk),
        .sys_rst (sys_rst),
        .d       ({cs_n, sck, si, hold_n, wp_n}),
        .q       (syn)
    );
    assign {s_cs_n, s_sck, s_si, s_hold_n, s_wp_n} = syn;

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            sck_prev_q <= 1'b0;
            cs_prev_q  <= 1'b1;
        end else begin
            sck_prev_q <= s_sck;
            cs_prev_q  <= s_cs_n;
        end
    end

    assign sel      = !s_cs_n;
    assign sck_rise = s_sck && !sck_prev_q;
    assign sck_fall = !s_sck && sck_prev_q;
    assign cs_rise  = s_cs_n && !cs_prev_q;
    assign cs_fall  = !s_cs_n && cs_prev_q;

    pause_ctrl u_pause (
        .clk     (clk),
        .sys_rst (sys_rst),
        .sel     (sel),
        .sck_lvl (s_sck),
        .hold_n  (s_hold_n),
        .paused  (paused)
    );

    // paused edges are dropped, state is kept as is
    assign rise_ok = sel && !paused && sck_rise;
    assign fall_ok = sel && !paused && sck_fall;
    assign opc_in  = {sr_q[6:0], s_si};

    // ======================================================
    // status word, read-only flags in the low bits
    always_comb begin
        status_w = 8'h00;
        status_w[SB_BUSY]             = busy_q;
        status_w[SB_LTCH]             = wel_q;
        status_w[SB_BP_HI:SB_BP_LO]   = bp_q;
        status_w[SB_PPE]              = ppe_q;
    end

    // ======================================================
    // sequencer, status bits and self-timed cycle
    always_comb begin
        st_d     = st_q;
        sr_d     = sr_q;
        op_d     = op_q;
        obyte_d  = obyte_q;
        wdata_d  = wdata_q;
        bitn_d   = bitn_q;
        obit_d   = obit_q;
        addr_d   = addr_q;
        bp_d     = bp_q;
        tmr_d    = tmr_q;
        pop_d    = pop_q;
        done_d   = done_q;
        so_d     = so_q;
        rd_req_d = 1'b0;
        wr_stb_d = 1'b0;
        pstart_d = 1'b0;
        armed_d  = armed_q || sel;
        wel_d    = wel_q;
        ppe_d    = ppe_q;
        dsleep_d = dsleep_q;
        busy_d   = busy_q;
        // the timer ignores select and the protect pin
        if (busy_q) begin
            tmr_d = tmr_q - TMR_W'(1);
            if (tmr_q == TMR_W'(1)) begin
                busy_d = 1'b0;
                wel_d  = 1'b0;
            end
        end
        if (rd_pend_q) begin
            obyte_d = arr_rd_data;
        end
        // page writes wrap inside the page
        if (wr_stb_q) begin
            addr_d = {addr_q[ADDR_W-1:PAGE_W], addr_q[PAGE_W-1:0] + PAGE_W'(1)};
        end
        if (cs_rise) begin
            st_d = ST_STANDBY;
            if (done_q) begin
                case (op_q)
                    OPC_LSET: wel_d = 1'b1;
                    OPC_LCLR: wel_d = 1'b0;
                    OPC_SLEEP: dsleep_d = 1'b1;
                    default: begin
                        // protect pin is looked at only here, never later
                        if (wel_q && !(op_q == OPC_STWR && !s_wp_n && ppe_q)) begin
                            busy_d   = 1'b1;
                            pstart_d = 1'b1;
                            tmr_d    = TMR_W'(WRITE_CYC);
                            unique case (op_q)
                                OPC_STWR: begin
                                    pop_d = OP_STATUS;
                                    bp_d  = sr_q[SB_BP_HI:SB_BP_LO];
                                    ppe_d = sr_q[SB_PPE];
                                end
                                OPC_PGER: pop_d = OP_PAGE_ER;
                                OPC_SCER: begin
                                    pop_d = OP_SECT_ER;
                                    tmr_d = TMR_W'(ERASE_CYC);
                                end
                                OPC_CE: begin
                                    pop_d = OP_CHIP_ER;
                                    tmr_d = TMR_W'(ERASE_CYC);
                                end
                                default: pop_d = OP_WRITE;
                            endcase
                        end
                    end
                endcase
            end
            done_d = 1'b0;
        end else if (cs_fall && armed_q) begin
            st_d   = ST_OPC;
            bitn_d = 5'd0;
            done_d = 1'b0;
        end else if (rise_ok) begin
            sr_d   = opc_in;
            bitn_d = bitn_q + 5'd1;
            done_d = 1'b0;
            unique case (st_q)
                ST_OPC: begin
                    if (bitn_q == 5'd7) begin
                        op_d   = opc_in;
                        bitn_d = 5'd0;
                        st_d   = ST_SKIP;
                        obit_d = 3'd0;
                        if (dsleep_q) begin
                            if (opc_in == OPC_WAKE) begin
                                dsleep_d = 1'b0;
                                st_d     = ST_ADDR;
                            end
                        end else if (busy_q) begin
                            if (opc_in == OPC_STRD) begin
                                st_d    = ST_SROUT;
                                obyte_d = status_w;
                            end
                        end else begin
                            case (opc_in)
                                OPC_READ, OPC_WRITE, OPC_PGER, OPC_SCER, OPC_WAKE:
                                    st_d = ST_ADDR;
                                OPC_STRD: begin
                                    st_d    = ST_SROUT;
                                    obyte_d = status_w;
                                end
                                OPC_STWR: st_d = ST_SRIN;
                                OPC_LSET, OPC_LCLR, OPC_CE, OPC_SLEEP:
                                    done_d = 1'b1;
                                default: done_d = 1'b0;
                            endcase
                        end
                    end
                end
                ST_ADDR: begin
                    // upper address bits shift out of the top
                    addr_d = {addr_q[ADDR_W-2:0], s_si};
                    if (bitn_q == 5'(ADDR_BITS - 1)) begin
                        bitn_d = 5'd0;
                        case (op_q)
                            OPC_READ: begin
                                st_d     = ST_RDATA;
                                rd_req_d = 1'b1;
                            end
                            OPC_WRITE: st_d = ST_WDATA;
                            OPC_WAKE: begin
                                st_d    = ST_SIGOUT;
                                obyte_d = SIGNATURE;
                            end
                            default: begin
                                st_d   = ST_SKIP;
                                done_d = 1'b1;
                            end
                        endcase
                    end
                end
                ST_WDATA: begin
                    if (bitn_q == 5'd7) begin
                        bitn_d   = 5'd0;
                        wr_stb_d = 1'b1;
                        wdata_d  = opc_in;
                        done_d   = 1'b1;
                    end
                end
                ST_SRIN: begin
                    if (bitn_q == 5'd7) begin
                        st_d   = ST_SKIP;
                        done_d = 1'b1;
                    end
                end
                default: bitn_d = 5'd0;
            endcase
        end else if (fall_ok && out_st) begin
            so_d   = obyte_q[3'd7 - obit_q];
            obit_d = obit_q + 3'd1;
            if (obit_q == 3'd7) begin
                if (st_q == ST_RDATA) begin
                    addr_d   = addr_q + ADDR_W'(1);
                    rd_req_d = 1'b1;
                end else if (st_q == ST_SROUT) begin
                    obyte_d = status_w;
                end
            end
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            st_q      <= ST_STANDBY;
            sr_q      <= 8'h00;
            op_q      <= 8'h00;
            obyte_q   <= 8'h00;
            wdata_q   <= 8'h00;
            bitn_q    <= 5'd0;
            obit_q    <= 3'd0;
            addr_q    <= '0;
            bp_q      <= BP_RST;
            tmr_q     <= '0;
            pop_q     <= OP_WRITE;
            done_q    <= 1'b0;
            so_q      <= 1'b0;
            rd_req_q  <= 1'b0;
            rd_pend_q <= 1'b0;
            wr_stb_q  <= 1'b0;
            pstart_q  <= 1'b0;
            armed_q   <= 1'b0;
            wel_q     <= 1'b0;
            ppe_q     <= PPE_RST;
            dsleep_q  <= 1'b0;
            busy_q    <= 1'b0;
        end else begin
            st_q      <= st_d;
            sr_q      <= sr_d;
            op_q      <= op_d;
            obyte_q   <= obyte_d;
            wdata_q   <= wdata_d;
            bitn_q    <= bitn_d;
            obit_q    <= obit_d;
            addr_q    <= addr_d;
            bp_q      <= bp_d;
            tmr_q     <= tmr_d;
            pop_q     <= pop_d;
            done_q    <= done_d;
            so_q      <= so_d;
            rd_req_q  <= rd_req_d;
            rd_pend_q <= rd_req_q;
            wr_stb_q  <= wr_stb_d;
            pstart_q  <= pstart_d;
            armed_q   <= armed_d;
            wel_q     <= wel_d;
            ppe_q     <= ppe_d;
            dsleep_q  <= dsleep_d;
            busy_q    <= busy_d;
        end
    end

    // ======================================================
    // outputs; the pause pin floats the output with no wait
    assign out_st      = (st_q == ST_RDATA) || (st_q == ST_SROUT) || (st_q == ST_SIGOUT);
    assign so_oe       = sel && s_hold_n && out_st;
    assign so_o        = so_q;
    assign arr_addr    = addr_q;
    assign arr_rd_req  = rd_req_q;
    assign arr_wr_stb  = wr_stb_q;
    assign arr_wr_data = wdata_q;
    assign prog_start  = pstart_q;
    assign prog_op     = pop_q;
    assign standby     = !sel && !busy_q;
    assign deep_sleep  = dsleep_q;
    assign status      = status_w;

    // ======================================================
    // checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    a_float_desel: assert property (!sel |-> !so_oe)
        else $error("output driven while deselected");
    a_float_pause: assert property (!s_hold_n |-> !so_oe)
        else $error("output driven while pause low");
    a_so_on_fall: assert property ($changed(so_q) |-> $past(fall_ok))
        else $error("output changed off a falling edge");
    a_unarmed_idle: assert property (cs_fall && !armed_q |=> st_q == ST_STANDBY)
        else $error("sequence began before first select low");
    a_first_bit: assert property (st_q == ST_OPC && bitn_q == 5'd0 && rise_ok
        |=> sr_q[0] == $past(s_si) && bitn_q == 5'd1)
        else $error("first bit not taken on first rise");
    a_read_decode: assert property (st_q == ST_OPC && bitn_q == 5'd7 && rise_ok
        && opc_in == OPC_READ && !busy_q && !dsleep_q |=> st_q == ST_ADDR)
        else $error("read opcode not decoded");
    a_latch_set: assert property (cs_rise && done_q && op_q == OPC_LSET
        |=> wel_q)
        else $error("latch not set");
    a_latch_clr: assert property (cs_rise && done_q && op_q == OPC_LCLR
        |=> !wel_q)
        else $error("latch not cleared");
    a_write_start: assert property (cs_rise && done_q && op_q == OPC_WRITE && wel_q
        |=> prog_start && busy_q ##1 !prog_start && busy_q)
        else $error("write cycle not started");
    a_wp_block: assert property (cs_rise && done_q && op_q == OPC_STWR && !s_wp_n
        && ppe_q |=> !prog_start && $stable(bp_q))
        else $error("status write not blocked");
    a_cycle_runs: assert property (busy_q && tmr_q > TMR_W'(1) |=> busy_q)
        else $error("cycle cut short");
    a_standby_busy: assert property (busy_q |-> !standby)
        else $error("standby during cycle");

    c_write: cover property (cs_rise && done_q && op_q == OPC_WRITE && wel_q);
    c_read: cover property (st_q == ST_RDATA && arr_rd_req);
    c_status: cover property (st_q == ST_SROUT && busy_q && fall_ok);

endmodule
`default_nettype wire

// >>> tb/spi_host_model.sv
// host-side serial master model for the memory front end
`timescale 1ns/1ps
`default_nettype none
module spi_host_model (
    input  wire logic clk,           // bench clock
    input  wire logic so,            // serial data from device
    output var logic  cs_n   = 1'b1, // select, idle high
    output var logic  sck    = 1'b0, // still between frames
    output var logic  si     = 1'b0, // serial data to device
    output var logic  hold_n = 1'b1  // pause, idle high
);
    // half of the 400 ns link period, moved on the clock fall
    task automatic half();
        repeat (4) @(negedge clk);
    endtask
    // select low before the first rising edge
    task automatic open_frame();
        cs_n = 1'b0;
        half();
    endtask
    // released data line shows the inverse, not a stale bit
    task automatic close_frame();
        half();
        cs_n = 1'b1;
        si = ~si;
        half();
        half();
    endtask
    // msb first out; input read late in the high half
    task automatic xb(input logic [7:0] t, output logic [7:0] r);
        for (int i = 7; i >= 0; i--) begin
            si = t[i];
            half();
            sck = 1'b1;
            half();
            r[i] = so;
            sck = 1'b0;
        end
    endtask
endmodule
`default_nettype wire

// >>> tb/eeprom_front_end_tb.sv
// self-checking bench for the serial memory front end
`timescale 1ns/1ps
`default_nettype none
module eeprom_front_end_tb;
    import eeprom_fe_pkg::*;
    logic clk = 1'b0, sys_rst = 1'b1, wp_n = 1'b1;
    wire logic cs_n, sck, si, hold_n, so_o, so_oe, rd_req, wr_stb, start, standby, sleep;
    wire logic [16:0] arr_addr;
    wire logic [7:0] rd_data, wr_data, status;
    wire prog_op_t op;
    int err_count = 0, cmp_count = 0, cyc = 0, starts = 0, n0;
    logic [31:0] rng = 32'd35;
    logic [7:0] rx;
    logic [24:0] wr_seen;
    logic [16:0] ad;
    prog_op_t last_op;
    logic [7:0] opc [4] = '{OPC_WRITE, OPC_PGER, OPC_SCER, OPC_CE};
    prog_op_t eop [4] = '{OP_WRITE, OP_PAGE_ER, OP_SECT_ER, OP_CHIP_ER};
    assign rd_data = arr_addr[7:0] ^ 8'hA5; // array stand-in, held with address
    initial forever #25 clk = ~clk;
    // a floating output reads back inverted, so stale bits cannot pass
    spi_host_model u_spi_host_model (.clk(clk), .so(so_oe ? so_o : !so_o), .cs_n(cs_n),
        .sck(sck), .si(si),
        .hold_n(hold_n));
    eeprom_front_end #(.WRITE_CYC(50), .ERASE_CYC(80), .SIGNATURE(8'h3C)) u_eeprom_front_end (
        .clk(clk), .sys_rst(sys_rst), .cs_n(cs_n), .sck(sck), .si(si), .hold_n(hold_n),
        .wp_n(wp_n), .so_o(so_o), .so_oe(so_oe), .arr_addr(arr_addr), .arr_rd_req(rd_req),
        .arr_rd_data(rd_data), .arr_wr_stb(wr_stb), .arr_wr_data(wr_data),
        .prog_start(start), .prog_op(op), .standby(standby), .deep_sleep(sleep),
        .status(status));
    // pulse capture and hang guard
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (start) begin
            starts <= starts + 1;
            last_op <= op;
        end
        if (wr_stb) wr_seen <= {arr_addr, wr_data};
        if (cyc == 40000) begin
            err_count++;
            end_of_test();
        end
    end
    function automatic logic [31:0] xs(input logic [31:0] s);
        s ^= s << 13;
        s ^= s >> 17;
        return s ^ (s << 5);
    endfunction
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            err_count++;
            $display("MISMATCH t=%0t got %0h exp %0h", $time, got, exp);
        end
    endtask
    task automatic cmd(input logic [7:0] c, input int n, input logic [31:0] arg);
        u_spi_host_model.open_frame();
        u_spi_host_model.xb(c, rx);
        for (int i = n - 1; i >= 0; i--) u_spi_host_model.xb(arg[8*i +: 8], rx);
        u_spi_host_model.close_frame();
    endtask
    // bounded wait for the self-timed cycle to end
    task automatic idle();
        for (int i = 0; i < 400 && status[0] !== 1'b0; i++) @(negedge clk);
    endtask
    task automatic end_of_test();
        $display("compares %0d mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    initial begin
        repeat (16) @(negedge clk);
        sys_rst = 1'b0;
        chk({standby, status}, 9'h100);
        cmd(8'hFF, 0, 0); // arming frame
        cmd(OPC_LSET, 0, 0);
        chk(status, 8'h02);
        cmd(OPC_STWR, 1, 8'h8C);
        idle();
        chk(status, 8'h8C);
        cmd(OPC_STRD, 1, 0);
        chk(rx, 8'h8C);
        wp_n = 1'b0;
        cmd(OPC_LSET, 0, 0);
        cmd(OPC_STWR, 1, 0);
        chk(status, 8'h8E);
        cmd(OPC_LCLR, 0, 0);
        wp_n = 1'b1;
        cmd(OPC_LSET, 0, 0);
        cmd(OPC_STWR, 1, 0);
        idle();
        chk(status, 8'h00);
        $display("test status done");
        // read with a pause and an ignored clock pulse inside it
        rng = xs(rng);
        ad = rng[16:0];
        u_spi_host_model.open_frame();
        u_spi_host_model.xb(OPC_READ, rx);
        for (int i = 2; i >= 0; i--) u_spi_host_model.xb(8'(32'(ad) >> (8 * i)), rx);
        u_spi_host_model.hold_n = 1'b0;
        u_spi_host_model.half();
        chk(so_oe, 0);
        u_spi_host_model.sck = 1'b1;
        u_spi_host_model.half();
        u_spi_host_model.sck = 1'b0;
        u_spi_host_model.half();
        u_spi_host_model.hold_n = 1'b1;
        u_spi_host_model.half();
        chk(so_oe, 1);
        u_spi_host_model.xb(0, rx);
        chk(rx, ad[7:0] ^ 8'hA5);
        u_spi_host_model.close_frame();
        chk(so_oe, 0);
        $display("test read done");
        for (int k = 0; k < 4; k++) begin
            rng = xs(rng);
            ad = rng[16:0];
            cmd(OPC_LSET, 0, 0);
            n0 = starts;
            cmd(opc[k], k == 3 ? 0 : k == 0 ? 4 : 3, k == 0 ? {7'h0, ad, rng[31:24]} : 32'(ad));
            chk(starts, n0 + 1);
            chk(standby, 0);
            chk(last_op, eop[k]);
            if (k == 0) chk(wr_seen, {ad, rng[31:24]});
            idle();
            chk({standby, status}, 9'h100);
        end
        $display("test program done");
        // unknown opcode with the latch set must start nothing
        cmd(OPC_LSET, 0, 0);
        n0 = starts;
        cmd(8'h5F, 1, 8'h02);
        chk(starts, n0);
        chk(status, 8'h02);
        cmd(OPC_SLEEP, 0, 0);
        chk(sleep, 1);
        cmd(OPC_WAKE, 4, 0);
        chk({sleep, rx}, 9'h03C);
        $display("test sleep done");
        end_of_test();
    end
endmodule
`default_nettype wire
